// >>> verilog/id_auth_erase_cmd_handler.sv
// identity authentication and erase command handler with apb registers
//
// Local design decisions: the address map and the APB register port.
`default_nettype none
//
// Operation
// - drop link bytes until a start-of-header byte opens a packet
// - missing end byte answers packet error
// - checksum mismatch answers checksum error
// - wrong length bytes answer packet error
// - any framing or acceptance error skips processing, flash untouched, wait again
// - no stored identity or already authenticated answers acceptance error
// - stored identity top bit zero answers serial disable error, no flash access
// - after a fatal error ignore every command and stay silent
// - compare identities unless bit 126 is set and keyword received
// - identity mismatch answers mismatch error, flash untouched
// - identity match answers ok and opens command acceptance
// - any permanent protect bit on erase path answers protection error
// - serial protect bit zero on erase path answers protection error
// - failed erase answers flash access error
// - good erase answers ok and opens command acceptance
// - ok packet carries fixed framing, length, result and status bytes
// - error packet uses same framing with error result and status fields
// - flash error gives flash status, address only when disclosed
module id_auth_erase_cmd_handler
    import id_auth_pkg::*;
#(
    parameter int PROT_W = 8
) (
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [7:0]          paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire logic                rx_valid,
    input  wire logic [7:0]          rx_data,
    output logic                     tx_valid,
    output logic [7:0]               tx_data,
    input  wire logic                tx_ready,
    input  wire logic [127:0]        stored_id,
    input  wire logic [PROT_W-1:0]   permanent_protect,
    input  wire logic                serial_program_protect_bit,
    output logic                     erase_req,
    input  wire logic                erase_done,
    input  wire logic                erase_fail,
    input  wire logic [31:0]         flash_status,
    input  wire logic [31:0]         fail_addr,
    input  wire logic                fail_addr_disclosed
);
    import id_auth_pkg::*;

    // decision sequencing states
    typedef enum {S_WAIT, S_ERASE, S_SEND} state_type;

    state_type   st_q, st_d;
    logic        en_q, en_d;
    logic        locked_q, locked_d;
    logic        auth_q, auth_d;
    logic        erase_q, erase_d;
    logic        start_q, start_d;
    logic [7:0]  res_q, res_d, sts_q, sts_d;
    logic [31:0] det_q, det_d, adr_q, adr_d;
    logic [31:0] prdata_q, prdata_d;
    logic        slverr_q, slverr_d;

    logic         pkt_done, etx_bad, sum_bad, len_bad;
    logic [7:0]   cmd_code;
    logic [127:0] id_field;
    logic         tx_busy;
    logic         listen;
    logic         frame_err;
    logic         no_id;
    logic         keyword_path;

    // bytes arriving while busy or locked are simply dropped
    assign listen = en_q && !locked_q && (st_q == S_WAIT);

    // link receive side
    cmd_packet_framer u_framer (
        .pclk     (pclk),
        .presetn  (presetn),
        .enable   (listen),
        .rx_valid (rx_valid),
        .rx_data  (rx_data),
        .pkt_done (pkt_done),
        .etx_bad  (etx_bad),
        .sum_bad  (sum_bad),
        .len_bad  (len_bad),
        .cmd_code (cmd_code),
        .id_field (id_field)
    );

    // link transmit side
    status_packet_sender u_sender (
        .pclk     (pclk),
        .presetn  (presetn),
        .start    (start_q),
        .result   (res_q),
        .status   (sts_q),
        .detail   (det_q),
        .address  (adr_q),
        .busy     (tx_busy),
        .tx_valid (tx_valid),
        .tx_data  (tx_data),
        .tx_ready (tx_ready)
    );

    assign frame_err    = etx_bad || sum_bad || len_bad;
    assign no_id        = (stored_id == {128{1'b1}});
    assign keyword_path = stored_id[126] && (id_field == ERASE_KEYWORD);

    // command decision and response sequencing
    always_comb begin
        st_d     = st_q;
        locked_d = locked_q;
        auth_d   = auth_q;
        erase_d  = erase_q;
        start_d  = 1'b0;
        res_d    = res_q;
        sts_d    = sts_q;
        det_d    = det_q;
        adr_d    = adr_q;
        case (st_q)
            S_WAIT: begin
                if (pkt_done && listen) begin
                    res_d   = RESULT_ERR;
                    det_d   = UNUSED_CODE;
                    adr_d   = UNUSED_CODE;
                    start_d = 1'b1;
                    st_d    = S_SEND;
                    if (etx_bad) begin
                        sts_d = STS_PACKET_ERR;
                    end else if (sum_bad) begin
                        sts_d = STS_CHECKSUM_ERR;
                    end else if (len_bad) begin
                        sts_d = STS_PACKET_ERR;
                    end else if (no_id || auth_q) begin
                        sts_d = STS_ACCEPT_ERR;
                    end else if (!stored_id[127]) begin
                        sts_d    = STS_SERIAL_DIS_ERR;
                        locked_d = 1'b1;
                    end else if (!keyword_path) begin
                        if (id_field != stored_id) begin
                            sts_d    = STS_ID_MISMATCH_ERR;
                            locked_d = 1'b1;
                        end else begin
                            res_d  = RESULT_OK;
                            sts_d  = STS_OK;
                            auth_d = 1'b1;
                        end
                    end else if (|permanent_protect) begin
                        sts_d    = STS_PROTECT_ERR;
                        locked_d = 1'b1;
                    end else if (!serial_program_protect_bit) begin
                        sts_d    = STS_PROTECT_ERR;
                        locked_d = 1'b1;
                    end else begin
                        start_d = 1'b0;
                        erase_d = 1'b1;
                        st_d    = S_ERASE;
                    end
                end
            end
            S_ERASE: begin
                if (erase_done) begin
                    erase_d = 1'b0;
                    start_d = 1'b1;
                    st_d    = S_SEND;
                    if (erase_fail) begin
                        res_d    = RESULT_ERR;
                        sts_d    = STS_FLASH_ACCESS_ERR;
                        det_d    = flash_status;
                        adr_d    = fail_addr_disclosed ? fail_addr : UNUSED_CODE;
                        locked_d = 1'b1;
                    end else begin
                        res_d  = RESULT_OK;
                        sts_d  = STS_OK;
                        auth_d = 1'b1;
                    end
                end
            end
            S_SEND: begin
                if (!start_q && !tx_busy) begin
                    st_d = S_WAIT;
                end
            end
            default: st_d = S_WAIT;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q     <= S_WAIT;
            locked_q <= 1'b0;
            auth_q   <= 1'b0;
            erase_q  <= 1'b0;
            start_q  <= 1'b0;
            res_q    <= RESULT_OK;
            sts_q    <= STS_OK;
            det_q    <= UNUSED_CODE;
            adr_q    <= UNUSED_CODE;
        end else begin
            st_q     <= st_d;
            locked_q <= locked_d;
            auth_q   <= auth_d;
            erase_q  <= erase_d;
            start_q  <= start_d;
            res_q    <= res_d;
            sts_q    <= sts_d;
            det_q    <= det_d;
            adr_q    <= adr_d;
        end
    end

    // held until the sequencer ends
    assign erase_req = erase_q;

    // apb slave, zero wait states
    always_comb begin
        en_d     = en_q;
        prdata_d = prdata_q;
        slverr_d = 1'b0;
        if (psel && !penable) begin
            prdata_d = 32'h0;
            case (paddr)
                CTRL_OFFSET: begin
                    prdata_d[CTRL_ENABLE_BIT] = en_q;
                end
                STATUS_OFFSET: begin
                    prdata_d[STAT_LOCKED_BIT]              = locked_q;
                    prdata_d[STAT_AUTH_BIT]                = auth_q;
                    prdata_d[STAT_BUSY_BIT]                = (st_q != S_WAIT);
                    prdata_d[STAT_STS_LSB +: 8]            = sts_q;
                end
                default: slverr_d = 1'b1;
            endcase
        end else if (psel && penable) begin
            slverr_d = slverr_q;
            if (pwrite && (paddr == CTRL_OFFSET)) begin
                en_d = pwdata[CTRL_ENABLE_BIT];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_q     <= CTRL_ENABLE_RESET;
            prdata_q <= 32'h0;
            slverr_q <= 1'b0;
        end else begin
            en_q     <= en_d;
            prdata_q <= prdata_d;
            slverr_q <= slverr_d;
        end
    end

    // slave outputs
    assign pready  = 1'b1;
    assign prdata  = prdata_q;
    assign pslverr = psel && penable && slverr_q;

    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_good_frame;
        pkt_done && listen && !frame_err;
    endsequence

    sequence s_erase_entry;
        s_good_frame ##0 (!no_id && !auth_q && stored_id[127] && keyword_path);
    endsequence

    sequence s_id_check;
        s_good_frame ##0 (!no_id && !auth_q && stored_id[127] && !keyword_path);
    endsequence

    AST_LOCK_SILENT: assert property (
        $past(locked_q) && locked_q |-> !start_q && st_q != S_ERASE)
        else $error("response started while locked");

    AST_ETX_FIRST: assert property (
        pkt_done && listen && etx_bad |=> start_q && sts_q == STS_PACKET_ERR)
        else $error("missing end byte not reported as packet error");

    AST_SUM_SECOND: assert property (
        pkt_done && listen && !etx_bad && sum_bad |=> start_q && sts_q == STS_CHECKSUM_ERR)
        else $error("checksum error not reported");

    AST_LEN_THIRD: assert property (
        pkt_done && listen && !etx_bad && !sum_bad && len_bad
        |=> start_q && sts_q == STS_PACKET_ERR)
        else $error("length error not reported");

    AST_ERR_NO_ERASE: assert property (
        pkt_done && listen && (frame_err || no_id || auth_q)
        |=> !erase_q && !locked_q ##1 !erase_q)
        else $error("erase or lock after a non-fatal error");

    AST_ACCEPT: assert property (
        s_good_frame ##0 (no_id || auth_q) |=> sts_q == STS_ACCEPT_ERR && res_q == RESULT_ERR)
        else $error("acceptance error not reported");

    AST_SERIAL_DIS: assert property (
        s_good_frame ##0 (!no_id && !auth_q && !stored_id[127])
        |=> locked_q && sts_q == STS_SERIAL_DIS_ERR && !erase_q)
        else $error("serial disable not reported or flash touched");

    AST_PROTECT: assert property (
        s_erase_entry ##0 (|permanent_protect) |=> sts_q == STS_PROTECT_ERR && !erase_q)
        else $error("protected erase went ahead");

    AST_ERASE_OK: assert property (
        st_q == S_ERASE && erase_done && !erase_fail
        |=> start_q && res_q == RESULT_OK && auth_q && !locked_q)
        else $error("successful erase not answered ok");

    AST_FLASH_ADDR: assert property (
        st_q == S_ERASE && erase_done && erase_fail && !fail_addr_disclosed
        |=> adr_q == UNUSED_CODE && det_q == $past(flash_status) && locked_q)
        else $error("undisclosed failure address leaked");

    AST_ID_BAD: assert property (
        s_id_check ##0 (id_field != stored_id) |=> locked_q && sts_q == STS_ID_MISMATCH_ERR)
        else $error("id mismatch missed");

    AST_ID_GOOD: assert property (
        s_id_check ##0 (id_field == stored_id) |=> auth_q && res_q == RESULT_OK)
        else $error("id match missed");

    AST_SPP: assert property (
        s_erase_entry ##0 (!serial_program_protect_bit) |=> locked_q && !erase_q)
        else $error("serial protect ignored");
endmodule : id_auth_erase_cmd_handler
`default_nettype wire

// >>> verilog/id_auth_pkg.sv
// constants shared by the identity authentication command handler
`default_nettype none
package id_auth_pkg;
    // link framing bytes
    localparam logic [7:0]   START_OF_HEADER_BYTE = 8'h01;
    localparam logic [7:0]   START_OF_DATA_BYTE   = 8'h81;
    localparam logic [7:0]   END_OF_PACKET_BYTE   = 8'h03;
    localparam logic [7:0]   CMD_AUTH             = 8'h30;
    localparam logic [15:0]  CMD_AUTH_LENGTH      = 16'h0011;
    localparam logic [15:0]  RESPONSE_LENGTH      = 16'h000a;
    localparam int           RESPONSE_BYTES       = 15;
    localparam int           ID_BYTES             = 16;
    // result byte values
    localparam logic [7:0]   RESULT_OK            = 8'h30;
    localparam logic [7:0]   RESULT_ERR           = 8'hb0;
    // status codes
    localparam logic [7:0]   STS_OK               = 8'h00;
    localparam logic [7:0]   STS_PACKET_ERR       = 8'hc1;
    localparam logic [7:0]   STS_CHECKSUM_ERR     = 8'hc2;
    localparam logic [7:0]   STS_ACCEPT_ERR       = 8'hc3;
    localparam logic [7:0]   STS_SERIAL_DIS_ERR   = 8'hc4;
    localparam logic [7:0]   STS_ID_MISMATCH_ERR  = 8'hc5;
    localparam logic [7:0]   STS_PROTECT_ERR      = 8'hc6;
    localparam logic [7:0]   STS_FLASH_ACCESS_ERR = 8'hc7;
    localparam logic [31:0]  UNUSED_CODE          = 32'h0fffffff;
    localparam logic [127:0] ERASE_KEYWORD        = 128'h414c6552_415345ff_ffffffff_ffffffff;
    // register map
    localparam logic [7:0]   CTRL_OFFSET          = 8'h00;
    localparam logic [7:0]   STATUS_OFFSET        = 8'h04;
    localparam int           CTRL_ENABLE_BIT      = 0;
    localparam logic         CTRL_ENABLE_RESET    = 1'b1;
    localparam int           STAT_LOCKED_BIT      = 0;
    localparam int           STAT_AUTH_BIT        = 1;
    localparam int           STAT_BUSY_BIT        = 2;
    localparam int           STAT_STS_LSB         = 8;
endpackage : id_auth_pkg
`default_nettype wire

// >>> verilog/cmd_packet_framer.sv
// receive framer for command packets on the byte link
`default_nettype none
module cmd_packet_framer
    import id_auth_pkg::*;
(
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         enable,
    input  wire logic         rx_valid,
    input  wire logic [7:0]   rx_data,
    output logic              pkt_done,
    output logic              etx_bad,
    output logic              sum_bad,
    output logic              len_bad,
    output logic [7:0]        cmd_code,
    output logic [127:0]      id_field
);
    typedef enum {F_IDLE, F_LNH, F_LNL, F_BODY, F_SUM, F_ETX} fstate_type;

    fstate_type   st_q, st_d;
    logic [15:0]  len_q, len_d, left_q, left_d;
    logic [7:0]   acc_q, acc_d, cmd_q, cmd_d;
    logic [127:0] id_q, id_d;
    logic         first_q, first_d, sbad_q, sbad_d;
    logic         done_q, done_d, ebad_q, ebad_d;

    always_comb begin
        st_d    = st_q;
        len_d   = len_q;
        left_d  = left_q;
        acc_d   = acc_q;
        cmd_d   = cmd_q;
        id_d    = id_q;
        first_d = first_q;
        sbad_d  = sbad_q;
        done_d  = 1'b0;
        ebad_d  = ebad_q;
        if (!enable) begin
            st_d = F_IDLE;
        end else if (rx_valid) begin
            case (st_q)
                F_IDLE: begin
                    if (rx_data == START_OF_HEADER_BYTE) begin
                        st_d  = F_LNH;
                        acc_d = 8'h00;
                    end
                end
                F_LNH: begin
                    len_d[15:8] = rx_data;
                    acc_d       = acc_q + rx_data;
                    st_d        = F_LNL;
                end
                F_LNL: begin
                    len_d   = {len_q[15:8], rx_data};
                    left_d  = {len_q[15:8], rx_data};
                    acc_d   = acc_q + rx_data;
                    first_d = 1'b1;
                    st_d    = ({len_q[15:8], rx_data} == 16'h0000) ? F_SUM : F_BODY;
                end
                F_BODY: begin
                    acc_d   = acc_q + rx_data;
                    first_d = 1'b0;
                    if (first_q) begin
                        cmd_d = rx_data;
                    end else begin
                        id_d = {id_q[119:0], rx_data};
                    end
                    left_d = left_q - 16'h0001;
                    if (left_q == 16'h0001) begin
                        st_d = F_SUM;
                    end
                end
                F_SUM: begin
                    sbad_d = (8'(acc_q + rx_data) != 8'h00);
                    st_d   = F_ETX;
                end
                F_ETX: begin
                    ebad_d = (rx_data != END_OF_PACKET_BYTE);
                    done_d = 1'b1;
                    st_d   = F_IDLE;
                end
                default: st_d = F_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q    <= F_IDLE;
            len_q   <= 16'h0000;
            left_q  <= 16'h0000;
            acc_q   <= 8'h00;
            cmd_q   <= 8'h00;
            id_q    <= 128'h0;
            first_q <= 1'b0;
            sbad_q  <= 1'b0;
            done_q  <= 1'b0;
            ebad_q  <= 1'b0;
        end else begin
            st_q    <= st_d;
            len_q   <= len_d;
            left_q  <= left_d;
            acc_q   <= acc_d;
            cmd_q   <= cmd_d;
            id_q    <= id_d;
            first_q <= first_d;
            sbad_q  <= sbad_d;
            done_q  <= done_d;
            ebad_q  <= ebad_d;
        end
    end

    assign pkt_done = done_q;
    assign etx_bad  = ebad_q;
    assign sum_bad  = sbad_q;
    // zero length breaks the general format, anything else the command's
    assign len_bad  = (len_q == 16'h0000) || (len_q != CMD_AUTH_LENGTH);
    assign cmd_code = cmd_q;
    assign id_field = id_q;
endmodule : cmd_packet_framer
`default_nettype wire

// >>> verilog/status_packet_sender.sv
// builds and sends one status data packet on the byte link
`default_nettype none
module status_packet_sender
    import id_auth_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        start,
    input  wire logic [7:0]  result,
    input  wire logic [7:0]  status,
    input  wire logic [31:0] detail,
    input  wire logic [31:0] address,
    output logic             busy,
    output logic             tx_valid,
    output logic [7:0]       tx_data,
    input  wire logic        tx_ready
);
    logic [3:0]  idx_q, idx_d;
    logic [7:0]  acc_q, acc_d, byte_q, byte_d;
    logic        busy_q, busy_d;
    logic [95:0] body_q, body_d;

    always_comb begin
        idx_d  = idx_q;
        acc_d  = acc_q;
        byte_d = byte_q;
        busy_d = busy_q;
        body_d = body_q;
        if (!busy_q && start) begin
            busy_d = 1'b1;
            idx_d  = 4'd0;
            acc_d  = 8'h00;
            byte_d = START_OF_DATA_BYTE;
            body_d = {RESPONSE_LENGTH, result, status, detail, address};
        end else if (busy_q && tx_ready) begin
            idx_d = idx_q + 4'd1;
            if (idx_q != 4'd0) begin
                acc_d = acc_q + byte_q;
            end
            if (idx_q < 4'd12) begin
                byte_d = body_q[95:88];
                body_d = {body_q[87:0], 8'h00};
            end else if (idx_q == 4'd12) begin
                byte_d = 8'(8'h00 - acc_q - byte_q);
            end else if (idx_q == 4'd13) begin
                byte_d = END_OF_PACKET_BYTE;
            end else begin
                busy_d = 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idx_q  <= 4'd0;
            acc_q  <= 8'h00;
            byte_q <= 8'h00;
            busy_q <= 1'b0;
            body_q <= 96'h0;
        end else begin
            idx_q  <= idx_d;
            acc_q  <= acc_d;
            byte_q <= byte_d;
            busy_q <= busy_d;
            body_q <= body_d;
        end
    end

    assign busy     = busy_q;
    assign tx_valid = busy_q;
    assign tx_data  = byte_q;
endmodule : status_packet_sender
`default_nettype wire

// >>> verification/link_host_model.sv
// host side of the byte link: sends command packets, collects responses
`default_nettype none
module link_host_model (
    input  wire logic       pclk,
    input  wire logic       slow,
    output logic            rx_valid,
    output logic [7:0]      rx_data,
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_data,
    output logic            tx_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] resp[$];
    initial begin
        rx_valid = 1'b0;
        rx_data  = 8'h00;
        tx_ready = 1'b0;
    end
    // slow host is ready on every other cycle, so it takes one byte per two cycles
    always @(posedge pclk) begin
        tx_ready <= slow ? ~tx_ready : 1'b1;
        if (tx_valid && tx_ready) begin
            resp.push_back(tx_data);
        end
    end
    task automatic send(input logic [7:0] q[$]);
        foreach (q[i]) begin
            @(posedge pclk);
            rx_valid <= 1'b1;
            rx_data  <= q[i];
        end
        @(posedge pclk);
        rx_valid <= 1'b0;
        rx_data  <= ~q[q.size()-1];
    endtask : send
endmodule : link_host_model
`default_nettype wire

// >>> verification/tb_id_auth_erase_cmd_handler.sv
// self-checking bench for the identity authentication and erase handler
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin failures++; \
    $display("ERROR %0t mismatch %h %h", $time, a, b); end end
module tb_id_auth_erase_cmd_handler;
    import id_auth_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, err, slow;
    logic         rx_valid, tx_valid, tx_ready, erase_req, erase_done, erase_fail, spp, discl;
    logic [7:0]   paddr, rx_data, tx_data, prot;
    logic [31:0]  pwdata, prdata, fstat, faddr, lfsr, rd;
    logic [127:0] sid;
    int           failures, total_checks, ecnt, erases;

    id_auth_erase_cmd_handler uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rx_valid(rx_valid), .rx_data(rx_data),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .stored_id(sid),
        .permanent_protect(prot), .serial_program_protect_bit(spp), .erase_req(erase_req),
        .erase_done(erase_done), .erase_fail(erase_fail), .flash_status(fstat),
        .fail_addr(faddr), .fail_addr_disclosed(discl));
    link_host_model host (.pclk(pclk), .slow(slow), .rx_valid(rx_valid), .rx_data(rx_data),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    // flash sequencer stand-in: erase ends six cycles after request
    always @(posedge pclk) begin
        ecnt       <= erase_req ? ecnt + 1 : 0;
        erase_done <= erase_req && ecnt == 5;
        if (erase_done) erases++;
    end

    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction : rnd
    function automatic logic [7:0] exp_byte(input int k, input logic [7:0] res, sts,
        input logic [31:0] st2, adr);
        logic [7:0] b[15];
        b = '{START_OF_DATA_BYTE, 8'h00, 8'h0a, res, sts, st2[31:24], st2[23:16], st2[15:8],
              st2[7:0], adr[31:24], adr[23:16], adr[15:8], adr[7:0], 8'h00, END_OF_PACKET_BYTE};
        for (int i = 1; i < 13; i++) b[13] -= b[i];
        return b[k];
    endfunction : exp_byte
    task automatic final_report();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : final_report
    task automatic rst();
        presetn <= 1'b0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
    endtask : rst
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        for (int n = 0; n < 20; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
            if (n == 19) begin failures++; final_report(); end
        end
        rd  = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask : apb
    // res of zero means the device must stay silent
    task automatic run(input logic [127:0] id, input logic [7:0] len, adj, tail, res, sts,
        input logic [31:0] st2 = UNUSED_CODE, adr = UNUSED_CODE);
        logic [7:0] q[$];
        int n;
        q = '{8'h55, START_OF_HEADER_BYTE, 8'h00, len, CMD_AUTH};
        for (int i = 15; i >= 17 - int'(len); i--) q.push_back(id[8*i +: 8]);
        for (int i = 2; i < q.size(); i++) adj -= q[i];
        q.push_back(adj);
        q.push_back(tail);
        slow <= 1'(rnd() >> 31);
        host.resp.delete();
        host.send(q);
        for (n = 0; n < 600 && host.resp.size() < 15; n++) @(posedge pclk);
        if (res === 8'h00) begin
            `CHK(host.resp.size(), 0)
        end else if (n == 600) begin
            failures++;
            $display("ERROR %0t no response", $time);
            final_report();
        end else begin
            for (int k = 0; k < 15; k++) `CHK(host.resp[k], exp_byte(k, res, sts, st2, adr))
        end
        $display("test done, %0d checks", total_checks);
    endtask : run

    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, slow} = '0;
        {erase_done, erase_fail, discl, ecnt, erases, failures, total_checks} = '0;
        {spp, prot, fstat, faddr, lfsr, sid} = {1'b1, 8'h00, 64'h0, 32'h26, {128{1'b1}}};
        rst();
        apb(1'b1, CTRL_OFFSET, 32'h0);
        run(sid, 8'h11, 0, 8'h03, 8'h00, 8'h00);
        apb(1'b1, CTRL_OFFSET, 32'h1);
        run(sid, 8'h11, 0, 8'h03, RESULT_ERR, STS_ACCEPT_ERR);
        apb(1'b0, 8'h08, 32'h0);
        `CHK({err, rd}, {1'b1, 32'h0})
        sid <= {2'b10, 30'(rnd()), rnd(), rnd(), rnd()};
        run(sid, 8'h11, 1, 8'h03, RESULT_ERR, STS_CHECKSUM_ERR);
        run(sid, 8'h11, 1, 8'h04, RESULT_ERR, STS_PACKET_ERR);
        run({16{8'h5a}}, 8'h10, 0, 8'h03, RESULT_ERR, STS_PACKET_ERR);
        run(sid, 8'h11, 0, 8'h03, RESULT_OK, STS_OK);
        run(sid, 8'h11, 0, 8'h03, RESULT_ERR, STS_ACCEPT_ERR);
        rst();
        sid[126] <= 1'b1;
        run({2'b11, sid[125:0]}, 8'h11, 0, 8'h03, RESULT_OK, STS_OK);
        rst();
        run(~sid, 8'h11, 0, 8'h03, RESULT_ERR, STS_ID_MISMATCH_ERR);
        run(sid, 8'h11, 0, 8'h03, 8'h00, 8'h00);
        apb(1'b0, STATUS_OFFSET, 32'h0);
        `CHK({rd[15:8], rd[0]}, {STS_ID_MISMATCH_ERR, 1'b1})
        rst();
        sid[127] <= 1'b0;
        run(sid, 8'h11, 0, 8'h03, RESULT_ERR, STS_SERIAL_DIS_ERR);
        rst();
        {sid[127], prot} <= {1'b1, 8'h10};
        run(ERASE_KEYWORD, 8'h11, 0, 8'h03, RESULT_ERR, STS_PROTECT_ERR);
        rst();
        {prot, spp} <= 9'h0;
        run(ERASE_KEYWORD, 8'h11, 0, 8'h03, RESULT_ERR, STS_PROTECT_ERR);
        `CHK(erases, 0)
        rst();
        spp <= 1'b1;
        run(ERASE_KEYWORD, 8'h11, 0, 8'h03, RESULT_OK, STS_OK);
        rst();
        {erase_fail, discl, fstat, faddr} <= {2'b11, rnd(), rnd()};
        @(posedge pclk);
        run(ERASE_KEYWORD, 8'h11, 0, 8'h03, RESULT_ERR, STS_FLASH_ACCESS_ERR, fstat, faddr);
        rst();
        discl <= 1'b0;
        run(ERASE_KEYWORD, 8'h11, 0, 8'h03, RESULT_ERR, STS_FLASH_ACCESS_ERR, fstat, UNUSED_CODE);
        `CHK(erases, 3)
        final_report();
    end
endmodule : tb_id_auth_erase_cmd_handler
`default_nettype wire
